//--- common/flash_guard_params.svh
/*
  timing counts, fuse encodings, reset values and address layout for the
  boot flash section guard. assumes a word-addressed 64k-byte flash (15-bit
  word address) and a 10 mhz core clock.
*/
`ifndef FLASH_GUARD_PARAMS_SVH
`define FLASH_GUARD_PARAMS_SVH

`define FG_ADDR_W          15
// first word address of the halting area (fixed boundary)
`define FG_HALT_START      15'h7000
// boot area start per boot_size_select code (00 largest .. 11 smallest)
`define FG_BOOT_START_00   15'h7000
`define FG_BOOT_START_01   15'h7800
`define FG_BOOT_START_10   15'h7C00
`define FG_BOOT_START_11   15'h7E00
// lock field reset value: unprogrammed
`define FG_LOCK_RESET      2'h3
// arming window of the enable bit, in core cycles
`define FG_ARM_CYCLES      3'h4
// erase / write duration: time in ns, then cycles at the core rate
`define FG_PROG_TIME_NS    4500000
`define FG_CLK_PERIOD_NS   100
`define FG_PROG_CYCLES     (`FG_PROG_TIME_NS / `FG_CLK_PERIOD_NS)

`endif

//--- common/flash_guard_pkg.sv
/*
  types shared by the boot flash section guard and its leaves.
  assumes flash_guard_params.svh is on the include path.
*/
`include "flash_guard_params.svh"

package flash_guard_pkg;

  typedef logic [`FG_ADDR_W-1:0] word_addr_t;

  // one cpu flash access as presented by the core
  typedef struct packed {
    logic       store;      // program-store instruction issued
    logic       load;       // program-load instruction issued
    word_addr_t pc;         // address of the executing instruction
    word_addr_t target;     // flash word addressed by the pointer
  } flash_req_t;

  // pending self-program command armed by the control register
  typedef enum logic [2:0] {
    CMD_BUF_LOAD,
    CMD_ERASE,
    CMD_WRITE,
    CMD_LOCK_SET,
    CMD_REENABLE
  } prog_cmd_t;

  // classification of one address
  typedef struct packed {
    logic in_boot;
    logic in_halt;
  } area_class_t;

  typedef enum logic [1:0] {
    PS_IDLE,
    PS_BUSY_CONC,
    PS_BUSY_HALT
  } prog_state_t;

endpackage

//--- rtl/area_classifier.sv
/*
  classifies one flash word address against the fuse-selected boot
  boundary and the fixed halting-area boundary. purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none
`include "flash_guard_params.svh"

module area_classifier
  import flash_guard_pkg::*;
(
  // address and boundary
  input  wire word_addr_t  addr_i,
  input  wire word_addr_t  boot_start_i,
  // result
  output var area_class_t  class_o
);

  // boot start is never below the halting start, so boot implies halt
  logic boot_hit;
  logic halt_hit;
  assign boot_hit = (addr_i >= boot_start_i);
  assign halt_hit = (addr_i >= `FG_HALT_START);
  // one driver for the whole struct keeps lint quiet about part drivers
  assign class_o  = '{in_boot: boot_hit, in_halt: halt_hit};

endmodule

`default_nettype wire

//--- rtl/lock_field.sv
/*
  one two-bit boot lock field. bits may only go from one to zero by
  software or the programming paths; only chip erase or sys_rst_i brings them back.
*/
`timescale 1ns/1ps
`default_nettype none
`include "flash_guard_params.svh"

module lock_field
  import flash_guard_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       sys_rst_i,
  // programming
  input  wire logic       set_i,
  input  wire logic [1:0] data_i,
  input  wire logic       chip_erase_i,
  // decoded protection
  output logic [1:0]      field_o,
  output logic            no_store_o,
  output logic            no_cross_load_o
);

  logic [1:0] field_q;
  logic [1:0] field_d;

  // bits can only be programmed (cleared); erase restores all ones
  assign field_d = chip_erase_i ? `FG_LOCK_RESET :
                   set_i        ? (field_q & data_i) : field_q;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      field_q <= `FG_LOCK_RESET;
    end else begin
      field_q <= field_d;
    end
  end

  assign field_o = field_q;
  // modes 2 and 3 block stores: low bit programmed
  assign no_store_o      = ~field_q[0];
  // modes 3 and 4 block cross-area loads: high bit programmed
  assign no_cross_load_o = ~field_q[1];

endmodule

`default_nettype wire

//--- rtl/boot_flash_section_guard.sv
/*
  access guard for flash self-programming: classifies each store/load
  against the boot and halting areas, applies the two boot lock fields,
  runs a per-operation busy timer, stalls the cpu for halting-area work
  and keeps the concurrent-read-area busy flag. assumes the core presents
  at most one store or load per cycle, same clock, and that fuses and the
  general lock mode are static levels from the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "flash_guard_params.svh"

module boot_flash_section_guard
  import flash_guard_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = `FG_PROG_CYCLES
)
(
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       sys_rst_i,
  // fuses and device-level lock state
  input  wire logic [1:0] boot_size_select_i,
  input  wire logic [1:0] general_lock_mode_i,
  input  wire logic       vectors_in_boot_i,
  // control register command, one-cycle write strobe
  input  wire logic       ctrl_wr_i,
  input  wire prog_cmd_t  ctrl_cmd_i,
  // cpu access
  input  wire flash_req_t req_i,
  input  wire logic [1:0] app_lock_data_i,
  input  wire logic [1:0] boot_lock_data_i,
  // external programming paths
  input  wire logic       ext_lock_set_i,
  input  wire logic       chip_erase_i,
  // access results
  output logic            load_allow_o,
  output logic            store_accept_o,
  output logic            store_reject_o,
  output var prog_cmd_t   op_cmd_o,
  output var word_addr_t  op_addr_o,
  // cpu and status
  output logic            cpu_stall_o,
  output logic            app_area_busy_flag_o,
  output logic            prog_active_o,
  output logic            irq_mask_o,
  output logic [1:0]      app_lock_field_o,
  output logic [1:0]      boot_lock_field_o
);

  // the tie to general_lock_mode_i is deliberately absent from every
  // check below: that lock governs only external programming
  logic gen_lock_unused;
  assign gen_lock_unused = ^general_lock_mode_i;

  word_addr_t boot_start;
  assign boot_start = (boot_size_select_i == 2'h0) ? `FG_BOOT_START_00 :
                      (boot_size_select_i == 2'h1) ? `FG_BOOT_START_01 :
                      (boot_size_select_i == 2'h2) ? `FG_BOOT_START_10 :
                                                     `FG_BOOT_START_11;

  area_class_t pc_class;
  area_class_t tgt_class;

  area_classifier u_pc_class (
    .addr_i       (req_i.pc),
    .boot_start_i (boot_start),
    .class_o      (pc_class)
  );

  area_classifier u_tgt_class (
    .addr_i       (req_i.target),
    .boot_start_i (boot_start),
    .class_o      (tgt_class)
  );

  // arming window of the control register
  logic [2:0] arm_cnt_q;
  logic [2:0] arm_cnt_d;
  prog_cmd_t  arm_cmd_q;
  prog_cmd_t  arm_cmd_d;
  logic       armed;

  // busy timer and state
  prog_state_t ps_q;
  prog_state_t ps_d;
  logic [31:0] prog_cnt_q;
  logic [31:0] prog_cnt_d;
  logic        busy_q;
  logic        busy_d;

  // lock fields
  logic app_no_store;
  logic app_no_xload;
  logic boot_no_store;
  logic boot_no_xload;
  logic app_lock_set;
  logic boot_lock_set;

  assign armed = (arm_cnt_q != 3'h0);

  logic store_from_boot;
  assign store_from_boot = req_i.store & armed & pc_class.in_boot &
                           (ps_q == PS_IDLE);

  // target may be anywhere, lock permitting
  logic store_lock_block;
  logic is_page_op;
  logic store_ok;
  assign is_page_op = (arm_cmd_q == CMD_ERASE) | (arm_cmd_q == CMD_WRITE);
  assign store_lock_block = is_page_op &
                            (tgt_class.in_boot ? boot_no_store : app_no_store);
  assign store_ok = store_from_boot & ~store_lock_block;

  // page operation kicked off this cycle
  logic op_start;
  assign op_start = store_ok & is_page_op;

  // lock set through software or external path
  assign app_lock_set  = (store_ok & (arm_cmd_q == CMD_LOCK_SET)) | ext_lock_set_i;
  assign boot_lock_set = app_lock_set;

  lock_field u_app_lock (
    .ref_clk_i       (ref_clk_i),
    .sys_rst_i       (sys_rst_i),
    .set_i           (app_lock_set),
    .data_i          (app_lock_data_i),
    .chip_erase_i    (chip_erase_i),
    .field_o         (app_lock_field_o),
    .no_store_o      (app_no_store),
    .no_cross_load_o (app_no_xload)
  );

  lock_field u_boot_lock (
    .ref_clk_i       (ref_clk_i),
    .sys_rst_i       (sys_rst_i),
    .set_i           (boot_lock_set),
    .data_i          (boot_lock_data_i),
    .chip_erase_i    (chip_erase_i),
    .field_o         (boot_lock_field_o),
    .no_store_o      (boot_no_store),
    .no_cross_load_o (boot_no_xload)
  );

  // cross-area load blocking; busy area unreadable
  logic load_xblock;
  logic load_busy_block;
  assign load_xblock = (pc_class.in_boot & ~tgt_class.in_boot & app_no_xload) |
                       (~pc_class.in_boot & tgt_class.in_boot & boot_no_xload);
  assign load_busy_block = busy_q & ~tgt_class.in_halt;
  assign load_allow_o = req_i.load & ~load_xblock & ~load_busy_block;

  assign irq_mask_o = (vectors_in_boot_i & ~pc_class.in_boot & app_no_xload) |
                      (~vectors_in_boot_i & pc_class.in_boot & boot_no_xload);

  assign store_accept_o = store_ok;
  assign store_reject_o = req_i.store & ~store_ok;

  // arming: a write opens a window of four cycles, a boot-area store with no op running closes it
  assign arm_cnt_d = ctrl_wr_i ? `FG_ARM_CYCLES :
                     (store_from_boot | ~armed) ? 3'h0 : arm_cnt_q - 3'h1;
  assign arm_cmd_d = ctrl_wr_i ? ctrl_cmd_i : arm_cmd_q;

  always_comb begin
    ps_d       = ps_q;
    prog_cnt_d = prog_cnt_q;
    unique case (ps_q)
      PS_IDLE: begin
        if (op_start) begin
          ps_d       = tgt_class.in_halt ? PS_BUSY_HALT : PS_BUSY_CONC;
          prog_cnt_d = PROG_CYCLES - 32'd1;
        end
      end
      PS_BUSY_CONC, PS_BUSY_HALT: begin
        if (prog_cnt_q == 32'd0) begin
          ps_d = PS_IDLE;
        end else begin
          prog_cnt_d = prog_cnt_q - 32'd1;
        end
      end
      // unused fourth code falls back to idle
      default: begin
        ps_d = PS_IDLE;
      end
    endcase
  end

  // busy set on concurrent start, cleared by load or reenable
  logic busy_set;
  logic busy_clr;
  assign busy_set = op_start & ~tgt_class.in_halt;
  assign busy_clr = store_ok &
                    ((arm_cmd_q == CMD_BUF_LOAD) | (arm_cmd_q == CMD_REENABLE));
  // set wins over a clear in the same cycle
  assign busy_d = busy_set | (busy_q & ~busy_clr);

  // registered operation outputs
  prog_cmd_t  op_cmd_q;
  word_addr_t op_addr_q;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      arm_cnt_q  <= 3'h0;
      arm_cmd_q  <= CMD_BUF_LOAD;
      ps_q       <= PS_IDLE;
      prog_cnt_q <= 32'd0;
      busy_q     <= 1'b0;
      op_cmd_q   <= CMD_BUF_LOAD;
      op_addr_q  <= '0;
    end else begin
      arm_cnt_q  <= arm_cnt_d;
      arm_cmd_q  <= arm_cmd_d;
      ps_q       <= ps_d;
      prog_cnt_q <= prog_cnt_d;
      busy_q     <= busy_d;
      if (store_ok) begin
        op_cmd_q  <= arm_cmd_q;
        op_addr_q <= req_i.target;
      end
    end
  end

  // stall from the store through the end of a halting-area op
  assign cpu_stall_o = (ps_q == PS_BUSY_HALT) | (op_start & tgt_class.in_halt);
  assign app_area_busy_flag_o = busy_q;
  assign prog_active_o = (ps_q != PS_IDLE);
  assign op_cmd_o  = op_cmd_q;
  assign op_addr_o = op_addr_q;

endmodule

`default_nettype wire

//--- sim/guard_properties.sv
/*
  concurrent checks on the section guard ports.
  assumes a single core clock and the sim count of PROG_CYCLES.
*/
`timescale 1ns/1ps
`default_nettype none

module guard_properties
  import flash_guard_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = 8
)
(
  // clock, reset, fuses
  input wire logic       ref_clk_i,
  input wire logic       sys_rst_i,
  input wire logic [1:0] boot_size_select_i,
  input wire logic       vectors_in_boot_i,
  // requests
  input wire logic       ctrl_wr_i,
  input wire prog_cmd_t  ctrl_cmd_i,
  input wire flash_req_t req_i,
  input wire logic       chip_erase_i,
  // results
  input wire logic       load_allow_o,
  input wire logic       store_accept_o,
  input wire logic       store_reject_o,
  input wire word_addr_t op_addr_o,
  input wire logic       cpu_stall_o,
  input wire logic       app_area_busy_flag_o,
  input wire logic       irq_mask_o,
  input wire logic [1:0] app_lock_field_o,
  input wire logic [1:0] boot_lock_field_o
);
  // last armed command and a countdown of the page op
  prog_cmd_t   cmd_q;
  logic [15:0] cnt_q;
  logic        halt_q;
  word_addr_t  bs;
  wire logic   pe = (cmd_q == CMD_ERASE) || (cmd_q == CMD_WRITE);
  wire logic   op = store_accept_o && pe;
  assign bs = boot_size_select_i[1] ? (boot_size_select_i[0] ? 15'h7E00 : 15'h7C00)
                                    : (boot_size_select_i[0] ? 15'h7800 : 15'h7000);

  // countdown only, the window itself is left to the design
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cmd_q <= CMD_BUF_LOAD;
      cnt_q <= '0;
      halt_q <= 1'b0;
    end else begin
      if (ctrl_wr_i) cmd_q <= ctrl_cmd_i;
      if (op) cnt_q <= 16'(PROG_CYCLES);
      else if (cnt_q != 0) cnt_q <= cnt_q - 16'h0001;
      if (op) halt_q <= req_i.target >= 15'h7000;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  a_app_store_void: assert property (
    req_i.store && req_i.pc < bs |-> !store_accept_o) else $error("app store accepted");
  a_store_answered: assert property (
    req_i.store |-> store_accept_o != store_reject_o) else $error("store not answered");
  a_op_addr_latch: assert property (
    store_accept_o |=> op_addr_o == $past(req_i.target)) else $error("op address lost");
  a_conc_no_stall: assert property (
    cnt_q != 0 && !halt_q && !op |-> !cpu_stall_o) else $error("stall on concurrent op");
  a_halt_stall: assert property (
    (op && req_i.target >= 15'h7000) || (cnt_q > 1 && halt_q) |-> cpu_stall_o)
    else $error("halting op without stall");
  a_busy_on_start: assert property (
    op && req_i.target < 15'h7000 |=> app_area_busy_flag_o [*4]) else $error("busy not set");
  a_busy_clear: assert property (
    store_accept_o && (cmd_q == CMD_BUF_LOAD || cmd_q == CMD_REENABLE)
    |=> !app_area_busy_flag_o) else $error("busy not cleared");
  a_cross_load: assert property (
    req_i.load && ((req_i.pc >= bs && req_i.target < bs && !app_lock_field_o[1])
    || (req_i.pc < bs && req_i.target >= bs && !boot_lock_field_o[1])) |-> !load_allow_o)
    else $error("locked load allowed");
  a_lock_store: assert property (
    req_i.store && pe && (req_i.target >= bs ? !boot_lock_field_o[0] : !app_lock_field_o[0])
    |-> !store_accept_o) else $error("locked store accepted");
  a_irq_mask_on: assert property (
    (vectors_in_boot_i ? (req_i.pc < bs && !app_lock_field_o[1])
    : (req_i.pc >= bs && !boot_lock_field_o[1])) |-> irq_mask_o) else $error("irq not masked");
  a_lock_no_rise: assert property (
    !$past(chip_erase_i) |-> (app_lock_field_o & ~$past(app_lock_field_o)) == 2'b00
    && (boot_lock_field_o & ~$past(boot_lock_field_o)) == 2'b00) else $error("lock bit rose");
  a_erase_unlock: assert property (
    chip_erase_i |=> {app_lock_field_o, boot_lock_field_o} == 4'hF) else $error("erase failed");

  c_halt_op: cover property (op && req_i.target >= 15'h7000);
  c_reject: cover property (store_reject_o);
  c_load_block: cover property (req_i.load && !load_allow_o);
endmodule

bind boot_flash_section_guard guard_properties #(.PROG_CYCLES(PROG_CYCLES)) u_props (
  .ref_clk_i, .sys_rst_i, .boot_size_select_i, .vectors_in_boot_i, .ctrl_wr_i,
  .ctrl_cmd_i, .req_i, .chip_erase_i, .load_allow_o, .store_accept_o, .store_reject_o,
  .op_addr_o, .cpu_stall_o, .app_area_busy_flag_o, .irq_mask_o, .app_lock_field_o,
  .boot_lock_field_o);

`default_nettype wire

//--- sim/cpu_core_model.sv
/*
  core model presenting one store or load per call.
  assumes the guard stall output halts it on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module cpu_core_model
  import flash_guard_pkg::*;
(
  // clock and halt
  input  wire logic     ref_clk_i,
  input  wire logic     cpu_stall_i,
  // request toward the guard
  output var flash_req_t req_o
);
  // stall waits that ran out, read back by the bench
  int hang_cnt = 0;

  initial req_o = '0;

  // caller orders reenable before area reads
  task automatic issue(input flash_req_t r);
    int n;
    n = 0;
    // a halted core issues nothing
    while (cpu_stall_i !== 1'b0 && n < 200) begin
      @(posedge ref_clk_i);
      n++;
    end
    if (n == 200) hang_cnt++;
    @(posedge ref_clk_i);
    req_o <= r;
    @(negedge ref_clk_i);
  endtask

  // drop the request, even while halted
  task automatic idle();
    @(posedge ref_clk_i);
    req_o <= '0;
  endtask
endmodule

`default_nettype wire

//--- sim/boot_flash_section_guard_tb.sv
/*
  self-checking bench for the section guard: directed stores, random loads.
  assumes the checker binds itself and the core model drives the requests.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end

module boot_flash_section_guard_tb;
  import flash_guard_pkg::*;
  localparam int unsigned PC = 8;
  logic       ref_clk_i = 0, sys_rst_i = 1, ctrl_wr_i = 0, vectors_in_boot_i = 0;
  logic       ext_lock_set_i = 0, chip_erase_i = 0;
  logic [1:0] boot_size_select_i = 0, general_lock_mode_i = 0;
  logic [1:0] app_lock_data_i = 0, boot_lock_data_i = 0, app_lock_field_o, boot_lock_field_o;
  prog_cmd_t  ctrl_cmd_i = CMD_BUF_LOAD, op_cmd_o;
  flash_req_t req_i;
  word_addr_t op_addr_o, b;
  logic       load_allow_o, store_accept_o, store_reject_o, cpu_stall_o;
  logic       app_area_busy_flag_o, prog_active_o, irq_mask_o, v;
  int         num_errors = 0, num_checks = 0;
  logic [7:0] rnd = 8'h1E;

  always #50 ref_clk_i = ~ref_clk_i;

  boot_flash_section_guard #(.PROG_CYCLES(PC)) uut (.ref_clk_i, .sys_rst_i,
    .boot_size_select_i, .general_lock_mode_i, .vectors_in_boot_i, .ctrl_wr_i, .ctrl_cmd_i,
    .req_i, .app_lock_data_i, .boot_lock_data_i, .ext_lock_set_i, .chip_erase_i,
    .load_allow_o, .store_accept_o, .store_reject_o, .op_cmd_o, .op_addr_o, .cpu_stall_o,
    .app_area_busy_flag_o, .prog_active_o, .irq_mask_o, .app_lock_field_o, .boot_lock_field_o);
  cpu_core_model cpu (.ref_clk_i, .cpu_stall_i(cpu_stall_o), .req_o(req_i));

  // short lfsr keeps the random run repeatable
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic word_addr_t bstart(input logic [1:0] f);
    return f[1] ? (f[0] ? 15'h7E00 : 15'h7C00) : (f[0] ? 15'h7800 : 15'h7000);
  endfunction
  // expected load result with busy clear
  function automatic logic exp_load(input word_addr_t p, t, input logic [1:0] a, o);
    if (p >= b && t < b) return a[1];
    if (p < b && t >= b) return o[1];
    return 1'b1;
  endfunction

  task automatic summarize();
    if (num_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // arm, then store two cycles later; waits out a running op first
  task automatic store(input prog_cmd_t c, input word_addr_t p, t, input logic acc);
    int n;
    // look at the settled level, away from the edge that moves it
    @(negedge ref_clk_i);
    for (n = 0; n < 50 && prog_active_o !== 1'b0; n++) @(negedge ref_clk_i);
    if (n == 50) begin
      num_errors++;
      summarize();
    end
    @(posedge ref_clk_i);
    ctrl_wr_i <= 1'b1;
    ctrl_cmd_i <= c;
    @(posedge ref_clk_i);
    ctrl_wr_i <= 1'b0;
    cpu.issue({1'b1, 1'b0, p, t});
    `CHK({store_accept_o, store_reject_o}, {acc, !acc})
    cpu.idle();
  endtask

  initial begin
    word_addr_t p, t;
    repeat (6) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    @(negedge ref_clk_i);
    `CHK({app_lock_field_o, boot_lock_field_o}, 4'hF)
    for (int f = 0; f < 4; f++) begin
      @(posedge ref_clk_i);
      boot_size_select_i <= 2'(f);
      b = bstart(2'(f));
      store(CMD_ERASE, b - 15'h0001, 15'h0100, 1'b0);
      store(CMD_ERASE, b, 15'h0100, 1'b1);
      @(negedge ref_clk_i);
      `CHK({app_area_busy_flag_o, prog_active_o, cpu_stall_o, op_addr_o, op_cmd_o}, {3'b110, 15'h0100, CMD_ERASE})
      cpu.issue({1'b0, 1'b1, b, 15'h7000});
      `CHK(load_allow_o, 1'b1)
      cpu.issue({1'b0, 1'b1, b, 15'h0100});
      `CHK(load_allow_o, 1'b0)
      cpu.idle();
      repeat (PC + 2) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      `CHK(app_area_busy_flag_o, 1'b1)
      store(f[0] ? CMD_REENABLE : CMD_BUF_LOAD, b, 15'h0000, 1'b1);
      @(negedge ref_clk_i);
      `CHK(app_area_busy_flag_o, 1'b0)
      store(CMD_WRITE, b, 15'h7100, 1'b1);
      for (int k = 1; k <= PC + 1; k++) begin
        @(negedge ref_clk_i);
        `CHK(cpu_stall_o, k <= PC)
      end
    end
    // external path sets app mode 2, boot stays open
    @(posedge ref_clk_i);
    app_lock_data_i <= 2'b10;
    boot_lock_data_i <= 2'b11;
    ext_lock_set_i <= 1'b1;
    @(posedge ref_clk_i);
    ext_lock_set_i <= 1'b0;
    @(negedge ref_clk_i);
    `CHK({app_lock_field_o, boot_lock_field_o}, 4'hB)
    store(CMD_ERASE, b, 15'h0100, 1'b0);
    store(CMD_ERASE, b, b, 1'b1);
    @(posedge ref_clk_i);
    app_lock_data_i <= 2'b01;
    boot_lock_data_i <= 2'b00;
    store(CMD_LOCK_SET, b, 15'h0000, 1'b1);
    @(negedge ref_clk_i);
    `CHK({app_lock_field_o, boot_lock_field_o}, 4'h0)
    store(CMD_WRITE, b, 15'h7E40, 1'b0);
    for (int i = 0; i < 40; i++) begin
      rnd = lfsr(rnd);
      p = {rnd[7] ? 6'h3F : rnd[5:0], rnd, 1'b0};
      v = rnd[2];
      @(posedge ref_clk_i);
      general_lock_mode_i <= rnd[1:0];
      vectors_in_boot_i <= v;
      rnd = lfsr(rnd);
      t = {rnd[7] ? 6'h3F : rnd[5:0], rnd, 1'b1};
      cpu.issue({1'b0, 1'b1, p, t});
      `CHK(load_allow_o, exp_load(p, t, 2'b00, 2'b00))
      `CHK(irq_mask_o, v ? p < b : p >= b)
    end
    cpu.idle();
    @(posedge ref_clk_i);
    chip_erase_i <= 1'b1;
    @(posedge ref_clk_i);
    chip_erase_i <= 1'b0;
    @(negedge ref_clk_i);
    `CHK({app_lock_field_o, boot_lock_field_o}, 4'hF)
    store(CMD_WRITE, b, 15'h0200, 1'b1);
    `CHK(cpu.hang_cnt, 0)
    summarize();
  end
endmodule

`default_nettype wire
